// *** core/pss_regs.svh ***
// Register offsets, field limits, source codes, reset values and timing counts
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_ADR_CTRL 6'h00
`define PSS_ADR_LOSS 6'h04
`define PSS_ADR_SLEEP 6'h08
`define PSS_ADR_WAKE 6'h0C
`define PSS_ADR_DISP 6'h10
`define PSS_ADR_STAT 6'h14
`define PSS_ADR_IRQ 6'h18
`define PSS_ADR_MASK 6'h1C
`define PSS_ADR_INPUT 6'h20
`define PSS_ADR_SCALED 6'h24
`define PSS_CTRL_RST 32'h0000_0100
`define PSS_LOSS_RST 32'h0000_0000
`define PSS_SLEEP_RST 32'h0000_0000
`define PSS_WAKE_RST 32'h0000_0000
`define PSS_DISP_RST 32'h2710_0000
`define PSS_MASK_RST 4'h0
`define PSS_TENTH_SEC 32'h05F5_E100
`define PSS_TENTH_CYC 32'h000F_4240
`define PSS_LOSS_MAX 8'h64
`define PSS_LOSS_TMAX 8'h64
`define PSS_FREQ_MAX 16'h4650
`define PSS_DLY_MAX 12'h9FB
`define PSS_GAIN_MAX 16'h270F
`define PSS_BIAS_MAX 16'h270F
`define PSS_SRC_AI1 3'h1
`define PSS_SRC_AI2 3'h2
`define PSS_SRC_SET 3'h4
`endif

// *** core/pss_pkg.sv ***
// Types for the supervision block
package pss_pkg;
   typedef enum logic [1:0] {LOSS_OFF = 2'd0, LOSS_WARN = 2'd1, LOSS_FAULT = 2'd2} pss_loss_mode_t;
   typedef enum logic [1:0] {SLP_OFF = 2'd0, SLP_ON = 2'd1, SLP_DI = 2'd2} pss_sleep_sel_t;
   typedef enum logic [2:0] {ST_RUN = 3'b001, ST_DECEL = 3'b010, ST_SLEEP = 3'b100} pss_state_t;
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic stb;
      logic cyc;
   } pss_wb_req_t;
   typedef struct packed {
      logic [31:0] dat;
      logic ack;
   } pss_wb_rsp_t;
   typedef struct packed {
      logic lossShow;
      logic conflict;
      logic faultRelay;
      logic runEnable;
      logic asleep;
   } pss_drive_t;
endpackage

// *** core/pss_qual_timer.sv ***
// Qualification timer in tenths of a second
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_qual_timer (
   input wire logic clock,
   input wire logic rstn,
   input wire logic cond,
   input wire logic [11:0] delay,
   input wire logic [31:0] tenthCycles,
   output logic done
);
   import pss_pkg::*;
   logic [31:0] sub_r;
   logic [11:0] tenths_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sub_r <= 32'h0000_0000;
         tenths_r <= 12'h000;
      end else if (!cond) begin
         sub_r <= 32'h0000_0000;
         tenths_r <= 12'h000;
      end else if (tenths_r < delay) begin
         if (sub_r >= tenthCycles - 32'd1) begin
            sub_r <= 32'h0000_0000;
            tenths_r <= tenths_r + 12'd1;
         end else begin
            sub_r <= sub_r + 32'd1;
         end
      end
   end
   assign done = cond && (tenths_r >= delay);
   a_timer_zero: assert property (@(posedge clock) disable iff (!rstn)
      !cond |=> tenths_r == 12'h000 && sub_r == 32'h0000_0000)
      else $error("qualification timer not cleared");
endmodule
`default_nettype wire

// *** core/pss_supervisor.sv ***
// Feedback loss, sleep and wake supervision with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_supervisor #(
   parameter logic [31:0] TENTH_CYCLES = `PSS_TENTH_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire pss_pkg::pss_wb_req_t wbReq,
   output pss_pkg::pss_wb_rsp_t wbRsp,
   input wire logic [15:0] analogIn1,
   input wire logic [15:0] analogIn2,
   input wire logic [15:0] outFreq,
   input wire logic [15:0] refFreq,
   input wire logic motorStopped,
   input wire logic sleepDi,
   output pss_pkg::pss_drive_t drive,
   output logic [15:0] targetValue,
   output logic [15:0] feedbackValue,
   output logic irq
);
   import pss_pkg::*;
   // Input pins are asynchronous to the control clock
   logic stopMeta_r, stop_r, diMeta_r, di_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stopMeta_r <= 1'b0;
         stop_r <= 1'b0;
         diMeta_r <= 1'b0;
         di_r <= 1'b0;
      end else begin
         stopMeta_r <= motorStopped;
         stop_r <= stopMeta_r;
         diMeta_r <= sleepDi;
         di_r <= diMeta_r;
      end
   end
   // Samples are words from the converter, assumed on this clock
   logic [31:0] ctrl_r, loss_r, sleep_r, wake_r, disp_r;
   logic [3:0] stat_r, mask_r;
   logic [31:0] rdData;
   logic ack_r;
   logic [31:0] rdDat_r;
   logic [31:0] scaled_r;
   logic wbHit, wbWr;
   logic [3:0] events;
   logic [31:0] wrMerge;
   logic conflict;
   logic [2:0] tgtSel, fbSel;
   assign wbHit = wbReq.cyc && wbReq.stb && !ack_r;
   assign wbWr = wbHit && wbReq.we;
   assign tgtSel = ctrl_r[10:8];
   assign fbSel = ctrl_r[14:12];
   always_comb begin
      wrMerge = rdData;
      for (int i = 0; i < 4; i++) begin
         if (wbReq.sel[i]) begin
            wrMerge[i*8 +: 8] = wbReq.dat[i*8 +: 8];
         end
      end
   end
   // Range check: a write with any field out of range is ignored, old value kept
   function automatic logic lossOk(input logic [31:0] v);
      lossOk = (v[7:0] <= `PSS_LOSS_MAX) && (v[15:8] <= `PSS_LOSS_TMAX);
   endfunction
   function automatic logic freqOk(input logic [31:0] v);
      freqOk = (v[15:0] <= `PSS_FREQ_MAX) && (v[27:16] <= `PSS_DLY_MAX);
   endfunction
   function automatic logic dispOk(input logic [31:0] v);
      dispOk = ({1'b0, v[14:0]} <= `PSS_BIAS_MAX) && (v[31:16] <= `PSS_GAIN_MAX);
   endfunction
   function automatic logic srcOk(input logic [31:0] v);
      srcOk = (v[1:0] != 2'd3) && (v[5:4] != 2'd3)
         && ((v[10:8] == `PSS_SRC_AI1) || (v[10:8] == `PSS_SRC_AI2) || (v[10:8] == `PSS_SRC_SET))
         && ((v[14:12] == `PSS_SRC_AI1) || (v[14:12] == `PSS_SRC_AI2))
         && (v[10:8] != v[14:12]);
   endfunction
   logic ctrlReject;
   assign ctrlReject = wbWr && (wbReq.adr[5:0] == `PSS_ADR_CTRL) && !srcOk(wrMerge);
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `PSS_CTRL_RST;
         loss_r <= `PSS_LOSS_RST;
         sleep_r <= `PSS_SLEEP_RST;
         wake_r <= `PSS_WAKE_RST;
         disp_r <= `PSS_DISP_RST;
         mask_r <= `PSS_MASK_RST;
      end else if (wbWr) begin
         case (wbReq.adr[5:0])
            `PSS_ADR_CTRL: if (srcOk(wrMerge)) ctrl_r <= wrMerge;
            `PSS_ADR_LOSS: if (lossOk(wrMerge)) loss_r <= wrMerge;
            `PSS_ADR_SLEEP: if (freqOk(wrMerge)) sleep_r <= wrMerge;
            `PSS_ADR_WAKE: if (freqOk(wrMerge)) wake_r <= wrMerge;
            `PSS_ADR_DISP: if (dispOk(wrMerge)) disp_r <= wrMerge;
            `PSS_ADR_MASK: mask_r <= wrMerge[3:0];
            default: ;
         endcase
      end
   end
   // Conflict alarm latches on a rejected control write until a good control write
   logic conflict_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         conflict_r <= 1'b0;
      end else if (ctrlReject) begin
         conflict_r <= 1'b1;
      end else if (wbWr && (wbReq.adr[5:0] == `PSS_ADR_CTRL)) begin
         conflict_r <= 1'b0;
      end
   end
   assign conflict = conflict_r;
   // Source selection; controller itself lives outside
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         targetValue <= 16'h0000;
         feedbackValue <= 16'h0000;
      end else begin
         case (tgtSel)
            `PSS_SRC_AI2: targetValue <= analogIn2;
            `PSS_SRC_SET: targetValue <= ctrl_r[31:16];
            default: targetValue <= analogIn1;
         endcase
         feedbackValue <= (fbSel == `PSS_SRC_AI2) ? analogIn2 : analogIn1;
      end
   end
   // Feedback percent of full scale, 16-bit range
   logic [7:0] fbPct;
   logic [23:0] fbMul;
   assign fbMul = feedbackValue * 8'd100;
   assign fbPct = fbMul[23:16];
   logic lossCond, lossDone, lossHit_r;
   pss_loss_mode_t lossMode;
   assign lossMode = pss_loss_mode_t'(ctrl_r[1:0]);
   assign lossCond = (lossMode != LOSS_OFF) && (fbPct < loss_r[7:0]);
   pss_qual_timer u_loss (
      .clock(clock),
      .rstn(rstn),
      .cond(lossCond),
      .delay({4'h0, loss_r[15:8]}),
      .tenthCycles(TENTH_CYCLES),
      .done(lossDone)
   );
   // Warning follows the condition; fault latches until mode change
   logic faultLatch_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lossHit_r <= 1'b0;
         faultLatch_r <= 1'b0;
      end else begin
         lossHit_r <= lossDone;
         if (lossDone && lossMode == LOSS_FAULT) begin
            faultLatch_r <= 1'b1;
         end else if (lossMode != LOSS_FAULT) begin
            faultLatch_r <= 1'b0;
         end
      end
   end
   // Sleep and wake sequencing
   pss_sleep_sel_t sleepSel;
   logic sleepAllow, sleepCond, wakeCond, sleepDone, wakeDone;
   pss_state_t state_r, state_nxt;
   assign sleepSel = pss_sleep_sel_t'(ctrl_r[5:4]);
   always_comb begin
      case (sleepSel)
         SLP_ON: sleepAllow = 1'b1;
         SLP_DI: sleepAllow = di_r;
         default: sleepAllow = 1'b0;
      endcase
   end
   assign sleepCond = sleepAllow && (state_r == ST_RUN) && (outFreq < sleep_r[15:0]);
   assign wakeCond = (state_r == ST_SLEEP) && (refFreq > wake_r[15:0]);
   pss_qual_timer u_sleep (
      .clock(clock),
      .rstn(rstn),
      .cond(sleepCond),
      .delay(sleep_r[27:16]),
      .tenthCycles(TENTH_CYCLES),
      .done(sleepDone)
   );
   pss_qual_timer u_wake (
      .clock(clock),
      .rstn(rstn),
      .cond(wakeCond),
      .delay(wake_r[27:16]),
      .tenthCycles(TENTH_CYCLES),
      .done(wakeDone)
   );
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: if (sleepDone) state_nxt = ST_DECEL;
         ST_DECEL: if (stop_r) state_nxt = ST_SLEEP;
         ST_SLEEP: if (wakeDone) state_nxt = ST_RUN;
         default: state_nxt = ST_RUN;
      endcase
      if (!sleepAllow && state_r != ST_RUN) begin
         state_nxt = ST_RUN;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end
   // Output stage ramps on its own once run is enabled again
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         drive <= '0;
      end else begin
         drive.lossShow <= lossDone || faultLatch_r;
         drive.conflict <= conflict;
         drive.faultRelay <= faultLatch_r;
         drive.runEnable <= !faultLatch_r && (state_nxt == ST_RUN);
         drive.asleep <= (state_nxt == ST_SLEEP);
      end
   end
   // Display scaling: bias at 0 %, gain at 100 %, bias in sign-magnitude
   logic signed [17:0] span;
   logic signed [35:0] prod;
   logic signed [17:0] biasS;
   assign biasS = disp_r[15] ? -$signed({3'b000, disp_r[14:0]}) : $signed({3'b000, disp_r[14:0]});
   assign span = $signed({2'b00, disp_r[31:16]}) - biasS;
   assign prod = span * $signed({2'b00, feedbackValue});
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         scaled_r <= 32'h0000_0000;
      end else begin
         scaled_r <= 32'(biasS + 18'(prod >>> 16));
      end
   end
   // Interrupt events: loss, fault, sleep entry, conflict
   assign events = {ctrlReject, state_r == ST_DECEL && state_nxt == ST_SLEEP,
                    lossDone && !faultLatch_r && lossMode == LOSS_FAULT, lossDone && !lossHit_r};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stat_r <= 4'h0;
      end else if (wbWr && wbReq.adr[5:0] == `PSS_ADR_IRQ && wbReq.sel[0]) begin
         stat_r <= (stat_r & ~wbReq.dat[3:0]) | events;
      end else begin
         stat_r <= stat_r | events;
      end
   end
   assign irq = |(stat_r & mask_r);
   always_comb begin
      case (wbReq.adr[5:0])
         `PSS_ADR_CTRL: rdData = ctrl_r;
         `PSS_ADR_LOSS: rdData = loss_r;
         `PSS_ADR_SLEEP: rdData = sleep_r;
         `PSS_ADR_WAKE: rdData = wake_r;
         `PSS_ADR_DISP: rdData = disp_r;
         `PSS_ADR_STAT: rdData = {23'h0, drive.asleep, di_r, stop_r, conflict_r, faultLatch_r,
                                  lossDone, state_r[0], state_r[1], state_r[2]};
         `PSS_ADR_IRQ: rdData = {28'h0, stat_r};
         `PSS_ADR_MASK: rdData = {28'h0, mask_r};
         `PSS_ADR_INPUT: rdData = {feedbackValue, targetValue};
         `PSS_ADR_SCALED: rdData = scaled_r;
         default: rdData = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
         rdDat_r <= 32'h0000_0000;
      end else begin
         ack_r <= wbHit;
         if (wbHit) begin
            rdDat_r <= rdData;
         end
      end
   end
   // One driver for the whole response word, no split ownership
   assign wbRsp = '{dat: rdDat_r, ack: ack_r};
   a_fault_relay: assert property (@(posedge clock) disable iff (!rstn)
      lossDone && lossMode == LOSS_FAULT |=> ##1 drive.faultRelay && !drive.runEnable)
      else $error("fault relay missing after loss");
   a_warn_runs: assert property (@(posedge clock) disable iff (!rstn)
      lossDone && lossMode == LOSS_WARN && !faultLatch_r && state_nxt == ST_RUN |=> drive.lossShow && drive.runEnable)
      else $error("warning mode stopped drive");
   a_loss_off: assert property (@(posedge clock) disable iff (!rstn)
      lossMode == LOSS_OFF |-> !lossDone)
      else $error("loss seen while disabled");
   a_never_sleep: assert property (@(posedge clock) disable iff (!rstn)
      sleepSel == SLP_OFF |=> state_r == ST_RUN)
      else $error("sleep with selection zero");
   a_di_gate: assert property (@(posedge clock) disable iff (!rstn)
      sleepSel == SLP_DI && !di_r |-> !sleepCond)
      else $error("sleep timer ran without input");
   a_sleep_seq: assert property (@(posedge clock) disable iff (!rstn)
      state_r == ST_RUN && sleepDone |=> state_r == ST_DECEL ##1 !drive.runEnable)
      else $error("sleep entry sequence wrong");
   a_wake_run: assert property (@(posedge clock) disable iff (!rstn)
      state_r == ST_SLEEP && wakeDone && sleepAllow |=> state_r == ST_RUN && drive.runEnable == !$past(faultLatch_r))
      else $error("wake did not restart");
   a_conflict: assert property (@(posedge clock) disable iff (!rstn)
      ctrlReject |=> conflict_r && $stable(ctrl_r))
      else $error("same source accepted");
   a_timer_clear: assert property (@(posedge clock) disable iff (!rstn)
      !lossCond ##1 (lossCond && loss_r[15:8] != 8'h00) |-> !lossDone)
      else $error("loss timer not cleared");
   a_wb_ack: assert property (@(posedge clock) disable iff (!rstn)
      wbHit |=> ack_r ##1 !ack_r)
      else $error("wishbone ack timing");
   a_loss_show: assert property (@(posedge clock) disable iff (!rstn)
      lossDone |=> drive.lossShow)
      else $error("loss indication missing");
   a_warn_relay: assert property (@(posedge clock) disable iff (!rstn)
      lossMode == LOSS_WARN && !faultLatch_r |=> !drive.faultRelay)
      else $error("relay closed in warning mode");
   a_fault_hold: assert property (@(posedge clock) disable iff (!rstn)
      faultLatch_r && lossMode == LOSS_FAULT |=> faultLatch_r)
      else $error("fault latch dropped");
   a_asleep_halt: assert property (@(posedge clock) disable iff (!rstn)
      drive.asleep |-> !drive.runEnable)
      else $error("running while asleep");
   a_conflict_show: assert property (@(posedge clock) disable iff (!rstn)
      conflict_r |=> drive.conflict)
      else $error("conflict alarm not shown");
   a_status_sticky: assert property (@(posedge clock) disable iff (!rstn)
      events != 4'h0 |=> (stat_r & $past(events)) == $past(events))
      else $error("status event lost");
endmodule
`default_nettype wire

// *** tb/pss_motor_model.sv ***
// Motor output stage model with a ramped output frequency
`timescale 1ns/1ps
`default_nettype none
module pss_motor_model #(
   parameter logic [15:0] STEP = 16'h01F4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic runEnable,
   input wire logic [15:0] refFreq,
   output logic [15:0] outFreq,
   output logic motorStopped
);
   logic [15:0] goal;
   assign goal = runEnable ? refFreq : 16'h0000;
   // Ramp, never a jump, so a stop report lags the command
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         outFreq <= 16'h0000;
      end else if (17'(outFreq) + 17'(STEP) < 17'(goal)) begin
         outFreq <= outFreq + STEP;
      end else if (17'(outFreq) > 17'(goal) + 17'(STEP)) begin
         outFreq <= outFreq - STEP;
      end else begin
         outFreq <= goal;
      end
   end
   assign motorStopped = (outFreq == 16'h0000);
endmodule
`default_nettype wire

// *** tb/pss_supervisor_tb_top.sv ***
// Register-level bench for the supervision block
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_supervisor_tb_top;
   import pss_pkg::*;
   logic clock = 1'b0;
   logic rstn, sleepDi, motorStopped, irq;
   logic [15:0] ai1, ai2, refFreq, outFreq, tgt, fbk;
   logic [31:0] rd;
   pss_wb_req_t req;
   pss_wb_rsp_t rsp;
   pss_drive_t drive;
   int mismatches, total_checks;
   logic [31:0] srcCtl [3] = '{32'h1234_2100, 32'h1234_1200, 32'h1234_1400};
   logic [15:0] srcTgt [3] = '{16'h1111, 16'hF000, 16'h1234};
   logic [15:0] srcFb [3] = '{16'hF000, 16'h1111, 16'h1111};

   always #50 clock = ~clock;

   pss_supervisor #(.TENTH_CYCLES(32'd4)) u_dut (.clock(clock), .rstn(rstn), .wbReq(req), .wbRsp(rsp),
      .analogIn1(ai1), .analogIn2(ai2), .outFreq(outFreq), .refFreq(refFreq), .motorStopped(motorStopped),
      .sleepDi(sleepDi), .drive(drive), .targetValue(tgt), .feedbackValue(fbk), .irq(irq));
   pss_motor_model u_motor (.clock(clock), .rstn(rstn), .runEnable(drive.runEnable), .refFreq(refFreq),
      .outFreq(outFreq), .motorStopped(motorStopped));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // Slave answer time is never assumed; a wait ends on ack or after 64 cycles
   task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      req <= '{adr: {26'h0, a}, dat: d, sel: 4'hF, we: w, stb: 1'b1, cyc: 1'b1};
      do begin
         @(posedge clock);
         n++;
      end while (rsp.ack !== 1'b1 && n < 64);
      rd = rsp.dat;
      chk("ack", 1'b1, rsp.ack);
      req <= '0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wb(a, 1'b1, d);
   endtask
   task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0000_0000);
      chk(nm, e, rd);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      end_of_test;
   end

   initial begin
      rstn = 1'b0;
      sleepDi = 1'b0;
      ai1 = 16'h1111;
      ai2 = 16'hF000;
      refFreq = 16'h01F4;
      req = '0;
      mismatches = 0;
      total_checks = 0;
      repeat (16) @(posedge clock);
      chk("rstDrive", 5'h00, drive);
      rstn <= 1'b1;
      tick(1);
      chk("rstRun", 1'b1, drive.runEnable);
      rdc("ctrlRst", `PSS_ADR_CTRL, `PSS_CTRL_RST);
      rdc("dispRst", `PSS_ADR_DISP, `PSS_DISP_RST);
      rdc("maskRst", `PSS_ADR_MASK, 32'h0000_0000);
      rdc("hole", 6'h3C, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         wr(`PSS_ADR_CTRL, srcCtl[i]);
         tick(3);
         chk("tgt", srcTgt[i], tgt);
         chk("fb", srcFb[i], fbk);
      end
      rdc("input", `PSS_ADR_INPUT, 32'h1111_1234);
      wr(`PSS_ADR_CTRL, 32'h0000_1100);
      tick(2);
      chk("conf", 1'b1, drive.conflict);
      rdc("ctrlKeep", `PSS_ADR_CTRL, 32'h1234_1400);
      wr(`PSS_ADR_MASK, 32'h0000_0008);
      tick(1);
      chk("irqOn", 1'b1, irq);
      wr(`PSS_ADR_MASK, 32'h0000_0000);
      tick(1);
      chk("irqMask", 1'b0, irq);
      wr(`PSS_ADR_MASK, 32'h0000_0008);
      wr(`PSS_ADR_IRQ, 32'h0000_0008);
      tick(1);
      chk("irqClr", 1'b0, irq);
      wr(`PSS_ADR_CTRL, 32'h0000_2100);
      tick(2);
      chk("confClr", 1'b0, drive.conflict);
      $display("test sources done");
      wr(`PSS_ADR_LOSS, 32'h0000_0232);
      wr(`PSS_ADR_LOSS, 32'h0000_0265);
      rdc("lossRng", `PSS_ADR_LOSS, 32'h0000_0232);
      @(posedge clock);
      ai2 <= 16'h1000;
      tick(30);
      chk("off", 1'b0, drive.lossShow);
      wr(`PSS_ADR_CTRL, 32'h0000_2101);
      @(posedge clock);
      ai2 <= 16'hF000;
      tick(30);
      @(posedge clock);
      ai2 <= 16'h1000;
      tick(3);
      @(posedge clock);
      ai2 <= 16'hF000;
      tick(30);
      chk("early", 1'b0, drive.lossShow);
      @(posedge clock);
      ai2 <= 16'h1000;
      tick(30);
      chk("warn", 1'b1, drive.lossShow);
      chk("warnRun", 1'b1, drive.runEnable);
      chk("warnRly", 1'b0, drive.faultRelay);
      wr(`PSS_ADR_CTRL, 32'h0000_2102);
      tick(30);
      chk("flt", 1'b1, drive.lossShow);
      chk("fltRly", 1'b1, drive.faultRelay);
      chk("fltRun", 1'b0, drive.runEnable);
      wr(`PSS_ADR_CTRL, 32'h0000_2100);
      @(posedge clock);
      ai2 <= 16'h8000;
      tick(3);
      chk("fltOff", 1'b0, drive.faultRelay);
      $display("test loss done");
      wr(`PSS_ADR_DISP, 32'h012C_0064);
      tick(3);
      wb(`PSS_ADR_SCALED, 1'b0, 32'h0000_0000);
      chk("scale", 16'h00C8, rd[15:0]);
      wr(`PSS_ADR_DISP, 32'h012C_8064);
      tick(3);
      rdc("scaleNeg", `PSS_ADR_SCALED, 32'h0000_0064);
      wr(`PSS_ADR_SLEEP, 32'h0002_4651);
      rdc("slpRng", `PSS_ADR_SLEEP, 32'h0000_0000);
      wr(`PSS_ADR_SLEEP, 32'h0002_03E8);
      wr(`PSS_ADR_WAKE, 32'h0002_07D0);
      tick(40);
      chk("sel0", 1'b1, drive.runEnable);
      wr(`PSS_ADR_CTRL, 32'h0000_2120);
      tick(40);
      chk("diOff", 1'b1, drive.runEnable);
      wr(`PSS_ADR_CTRL, 32'h0000_2110);
      tick(40);
      chk("slp", 1'b1, drive.asleep);
      chk("slpRun", 1'b0, drive.runEnable);
      rdc("stat", `PSS_ADR_STAT, 32'h0000_0141);
      rdc("irqStat", `PSS_ADR_IRQ, 32'h0000_0007);
      @(posedge clock);
      refFreq <= 16'h0BB8;
      tick(2);
      chk("wakeDly", 1'b1, drive.asleep);
      tick(40);
      chk("wake", 1'b0, drive.asleep);
      chk("wakeRun", 1'b1, drive.runEnable);
      wr(`PSS_ADR_CTRL, 32'h0000_2120);
      @(posedge clock);
      refFreq <= 16'h01F4;
      sleepDi <= 1'b1;
      tick(40);
      chk("diSlp", 1'b1, drive.asleep);
      $display("test sleep done");
      end_of_test;
   end
endmodule
`default_nettype wire
